// file: ptrlb_bridge.sv
// pci target read path toward the local bus
`timescale 1ns/1ps
`include "ptrlb_defines.svh"
module ptrlb_bridge import ptrlb_pkg::*; #(
    parameter int          AW             = 4,
    parameter int          FIRST_FILL_W   = 8,
    parameter int          DPHASE_LEVEL_W = 8,
    parameter int          REFILL_LEVEL_W = 8,
    parameter logic [31:0] LB_BASE        = 32'h0000_0000,
    parameter logic [31:0] BAR_LEN        = 32'h0001_0000
) (
    // local bus clock and reset
    input  wire logic   clk_sys_i,
    input  wire logic   rst_i,
    // pci core side, on the pci clock
    input  wire logic   clk_pci_i,
    input  wire logic   pci_req_valid_i,
    input  ptrlb_pci_req_t pci_req_i,
    input  wire logic   pci_dphase_i,
    input  wire logic   pci_end_i,
    output logic        pci_req_ready_o,
    output logic        pci_rd_valid_o,
    output logic [31:0] pci_rd_data_o,
    output ptrlb_term_t pci_term_o,
    output logic        pci_err_strobe_o,
    // local bus master side
    output logic        lb_req_valid_o,
    output ptrlb_lb_req_t lb_req_o,
    input  ptrlb_lb_rsp_t lb_rsp_i
);
    localparam int OW = AW + 2;
    localparam logic [AW:0]   DEPTH_E  = {1'b1, {AW{1'b0}}};
    localparam logic [OW-1:0] TH_FIRST = OW'(FIRST_FILL_W);
    localparam logic [OW-1:0] TH_DPH   = OW'(DPHASE_LEVEL_W);
    localparam logic [OW-1:0] TH_REF   = OW'(REFILL_LEVEL_W);
    localparam logic [OW-1:0] ONE_W    = OW'(1);
    localparam logic [31:0]   ADDR_MSK = BAR_LEN - `PTRLB_LSB_ONE;
    localparam logic [31:0]   BASE_AL  = LB_BASE & ~ADDR_MSK;
    localparam logic [31:0]   LIM_ADDR = BASE_AL + BAR_LEN - `PTRLB_DW_BYTES;

    typedef enum logic [2:0] {
        P_IDLE   = 3'h0,
        P_SWAIT  = 3'h1,
        P_SDATA  = 3'h2,
        P_FILL   = 3'h3,
        P_STREAM = 3'h4,
        P_STOP   = 3'h5,
        P_RETRY  = 3'h6,
        P_FLUSH  = 3'h7
    } ptrlb_pstate_t;
    typedef enum logic [1:0] {
        S_IDLE  = 2'h0,
        S_ADDR  = 2'h1,
        S_DATA  = 2'h2,
        S_PAUSE = 2'h3
    } ptrlb_sstate_t;

    function automatic logic [AW:0] g2b(input logic [AW:0] g);
        logic [AW:0] b;
        b = g;
        for (int i = AW - 1; i >= 0; i--) begin
            b[i] = b[i + 1] ^ g[i];
        end
        return b;
    endfunction

    // -----------------------------------------------------------------
    // crossing signals
    // -----------------------------------------------------------------
    logic          rst_pci;
    logic [63:0]   mem_q [2**AW];
    ptrlb_xreq_t   xreq_p_q;
    logic          req_tgl_q;
    logic          stop_tgl_q;
    logic          evt_tgl_q;
    ptrlb_evt_t    evt_code_q;
    logic [31:0]   word_q;
    logic          stop_ack_q;
    logic [AW:0]   wr_bin_q;
    logic [AW:0]   wr_gray_q;
    logic [AW:0]   rd_ptr_q;
    logic [AW:0]   rd_gray_q;
    logic          req_s;
    logic          stop_s;
    logic          evt_s;
    logic          stop_ack_s;
    logic [AW:0]   wr_gray_s;
    logic [AW:0]   rd_gray_s;

    ptrlb_sync #(.W(1)) u_rst_sync (
        .clk_i (clk_pci_i),
        .rst_i (1'b0),
        .d_i   (rst_i),
        .q_o   (rst_pci)
    );
    ptrlb_sync #(.W(2)) u_to_sys (
        .clk_i (clk_sys_i),
        .rst_i (rst_i),
        .d_i   ({req_tgl_q, stop_tgl_q}),
        .q_o   ({req_s, stop_s})
    );
    ptrlb_sync #(.W(2)) u_to_pci (
        .clk_i (clk_pci_i),
        .rst_i (rst_pci),
        .d_i   ({evt_tgl_q, stop_ack_q}),
        .q_o   ({evt_s, stop_ack_s})
    );
    ptrlb_sync #(.W(AW + 1)) u_wr_ptr (
        .clk_i (clk_pci_i),
        .rst_i (rst_pci),
        .d_i   (wr_gray_q),
        .q_o   (wr_gray_s)
    );
    ptrlb_sync #(.W(AW + 1)) u_rd_ptr (
        .clk_i (clk_sys_i),
        .rst_i (rst_i),
        .d_i   (rd_gray_q),
        .q_o   (rd_gray_s)
    );

    // -----------------------------------------------------------------
    // pci side
    // -----------------------------------------------------------------
    ptrlb_pstate_t p_state_q;
    logic          evt_seen_q;
    logic          lim_q;
    logic          flush_q;
    logic          half_q;
    logic [1:0]    fl_cnt_q;
    logic [7:0]    phases_q;
    logic [AW:0]   wr_bin_p;
    logic [AW:0]   occ_ent;
    logic [OW-1:0] occ_w;
    logic [AW-1:0] rd_idx;
    logic [AW-1:0] rd_idx_nx;
    logic [31:0]   cur_word;
    logic [31:0]   nxt_word;
    logic          last_word;
    logic          evt_new;
    logic          is_single;
    logic          is_multi;
    logic [1:0]    low_lane;
    logic [31:0]   lb_addr_p;

    always_comb begin
        wr_bin_p  = g2b(wr_gray_s);
        occ_ent   = wr_bin_p - rd_ptr_q;
        occ_w     = {occ_ent, 1'b0} - {{(AW + 1){1'b0}}, half_q};
        rd_idx    = rd_ptr_q[AW-1:0];
        rd_idx_nx = rd_idx + AW'(1);
        cur_word  = half_q ? mem_q[rd_idx][63:32] : mem_q[rd_idx][31:0];
        nxt_word  = half_q ? mem_q[rd_idx_nx][31:0] : mem_q[rd_idx][63:32];
        last_word = (occ_w == ONE_W) ||
                    ((phases_q >= 8'(TH_DPH)) && (occ_w < TH_DPH));
        evt_new   = evt_s ^ evt_seen_q;
        is_single = (pci_req_i.cmd == `PTRLB_CMD_MEMRD);
        is_multi  = (pci_req_i.cmd == `PTRLB_CMD_MEMRDMUL) ||
                    (pci_req_i.cmd == `PTRLB_CMD_MEMRDLN);
        low_lane  = pci_req_i.be[0] ? 2'h0 : pci_req_i.be[1] ? 2'h1 :
                    pci_req_i.be[2] ? 2'h2 : pci_req_i.be[3] ? 2'h3 : 2'h0;
        lb_addr_p = BASE_AL | (pci_req_i.addr & ADDR_MSK);
    end

    assign pci_req_ready_o = (p_state_q == P_IDLE);
    assign pci_rd_valid_o  = (p_state_q == P_SDATA) || (p_state_q == P_STREAM);

    always_comb begin
        pci_term_o = PTRLB_TERM_NONE;
        if (p_state_q == P_RETRY) begin
            pci_term_o = PTRLB_TERM_RETRY;
        end else if (p_state_q == P_SDATA) begin
            pci_term_o = PTRLB_TERM_DISC_DATA;
        end else if ((p_state_q == P_STREAM) && last_word) begin
            pci_term_o = PTRLB_TERM_DISC_DATA;
        end
    end

    always_ff @(posedge clk_pci_i) begin
        if (rst_pci) begin
            p_state_q        <= P_IDLE;
            xreq_p_q         <= '0;
            req_tgl_q        <= 1'b0;
            stop_tgl_q       <= 1'b0;
            evt_seen_q       <= 1'b0;
            lim_q            <= 1'b0;
            flush_q          <= 1'b0;
            half_q           <= 1'b0;
            fl_cnt_q         <= '0;
            phases_q         <= '0;
            rd_ptr_q         <= '0;
            rd_gray_q        <= '0;
            pci_rd_data_o    <= '0;
            pci_err_strobe_o <= 1'b0;
        end else begin
            evt_seen_q       <= evt_s;
            rd_gray_q        <= (rd_ptr_q >> 1) ^ rd_ptr_q;
            pci_err_strobe_o <= 1'b0;
            unique case (p_state_q)
                P_IDLE: begin
                    if (pci_req_valid_i && (is_single || is_multi)) begin
                        req_tgl_q      <= ~req_tgl_q;
                        xreq_p_q.burst <= is_multi;
                        lim_q          <= 1'b0;
                        phases_q       <= '0;
                        if (is_single) begin
                            xreq_p_q.addr <= {lb_addr_p[31:2], low_lane};
                            xreq_p_q.be   <= pci_req_i.addr[`PTRLB_WORD_BIT] ?
                                {pci_req_i.be, `PTRLB_BE_LO_NONE} :
                                {`PTRLB_BE_LO_NONE, pci_req_i.be};
                            p_state_q     <= P_SWAIT;
                        end else begin
                            xreq_p_q.addr <= {lb_addr_p[31:2], 2'h0};
                            xreq_p_q.be   <= `PTRLB_BE_ALL;
                            half_q        <= pci_req_i.addr[`PTRLB_WORD_BIT];
                            p_state_q     <= P_FILL;
                        end
                    end
                end
                P_SWAIT: begin
                    if (evt_new) begin
                        if (evt_code_q == PTRLB_EV_DATA) begin
                            pci_rd_data_o <= word_q;
                            p_state_q     <= P_SDATA;
                        end else begin
                            pci_err_strobe_o <= (evt_code_q == PTRLB_EV_MERR);
                            flush_q          <= 1'b0;
                            p_state_q        <= P_RETRY;
                        end
                    end
                end
                P_SDATA: begin
                    if (pci_dphase_i || pci_end_i) begin
                        p_state_q <= P_IDLE;
                    end
                end
                P_FILL: begin
                    if (evt_new && (evt_code_q != PTRLB_EV_DATA)) begin
                        pci_err_strobe_o <= (evt_code_q == PTRLB_EV_MERR);
                        flush_q          <= 1'b1;
                        p_state_q        <= P_RETRY;
                    end else if (evt_new) begin
                        lim_q <= 1'b1;
                    end else if (pci_end_i) begin
                        stop_tgl_q <= ~stop_tgl_q;
                        p_state_q  <= P_STOP;
                    end else if ((occ_w >= TH_FIRST) || (lim_q && (occ_w != '0))) begin
                        pci_rd_data_o <= cur_word;
                        p_state_q     <= P_STREAM;
                    end
                end
                P_STREAM: begin
                    if (evt_new && (evt_code_q != PTRLB_EV_DATA)) begin
                        pci_err_strobe_o <= 1'b1;
                        flush_q          <= 1'b1;
                        p_state_q        <= P_RETRY;
                    end else if (pci_dphase_i) begin
                        if (phases_q != 8'hff) begin
                            phases_q <= phases_q + 8'h01;
                        end
                        if (last_word) begin
                            stop_tgl_q <= ~stop_tgl_q;
                            p_state_q  <= P_STOP;
                        end else begin
                            pci_rd_data_o <= nxt_word;
                            half_q        <= ~half_q;
                            if (half_q) begin
                                rd_ptr_q <= rd_ptr_q + (AW + 1)'(1);
                            end
                        end
                    end else if (pci_end_i) begin
                        stop_tgl_q <= ~stop_tgl_q;
                        p_state_q  <= P_STOP;
                    end
                end
                P_STOP: begin
                    if (stop_ack_s == stop_tgl_q) begin
                        fl_cnt_q  <= `PTRLB_FLUSH_WAIT;
                        p_state_q <= P_FLUSH;
                    end
                end
                P_RETRY: begin
                    fl_cnt_q  <= `PTRLB_FLUSH_WAIT;
                    p_state_q <= flush_q ? P_FLUSH : P_IDLE;
                end
                P_FLUSH: begin
                    if (fl_cnt_q != 2'h0) begin
                        fl_cnt_q <= fl_cnt_q - 2'h1;
                    end else begin
                        rd_ptr_q  <= wr_bin_p;
                        half_q    <= 1'b0;
                        p_state_q <= P_IDLE;
                    end
                end
                default: p_state_q <= P_IDLE;
            endcase
        end
    end

    // -----------------------------------------------------------------
    // local bus side
    // -----------------------------------------------------------------
    ptrlb_sstate_t s_state_q;
    ptrlb_xreq_t   xr_q;
    logic          req_seen_q;
    logic          first_q;
    logic [31:0]   cur_addr_q;
    logic [7:0]    beats_q;
    logic [AW:0]   fill_ent;
    logic [AW:0]   free_ent;
    logic [31:0]   to_lim;
    logic [7:0]    len_c;
    logic          wr_en;
    logic          last_beat;

    always_comb begin
        fill_ent  = wr_bin_q - g2b(rd_gray_s);
        free_ent  = DEPTH_E - fill_ent;
        to_lim    = ((LIM_ADDR - cur_addr_q) >> `PTRLB_DW_LSB) + `PTRLB_LSB_ONE;
        len_c     = (to_lim < 32'(free_ent)) ? to_lim[7:0] : 8'(free_ent);
        wr_en     = (s_state_q == S_DATA) && lb_rsp_i.rd_valid && !lb_rsp_i.merr &&
                    xr_q.burst;
        last_beat = lb_rsp_i.bterm || ((beats_q + 8'h01) == lb_req_o.len);
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            wr_bin_q  <= '0;
            wr_gray_q <= '0;
        end else begin
            wr_gray_q <= (wr_bin_q >> 1) ^ wr_bin_q;
            if (wr_en) begin
                wr_bin_q <= wr_bin_q + (AW + 1)'(1);
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (wr_en) begin
            mem_q[wr_bin_q[AW-1:0]] <= lb_rsp_i.rd_data;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            s_state_q      <= S_IDLE;
            xr_q           <= '0;
            req_seen_q     <= 1'b0;
            first_q        <= 1'b0;
            cur_addr_q     <= '0;
            beats_q        <= '0;
            lb_req_valid_o <= 1'b0;
            lb_req_o       <= '0;
            evt_tgl_q      <= 1'b0;
            evt_code_q     <= PTRLB_EV_DATA;
            word_q         <= '0;
            stop_ack_q     <= 1'b0;
        end else begin
            unique case (s_state_q)
                S_IDLE: begin
                    if (stop_s != stop_ack_q) begin
                        stop_ack_q <= stop_s;
                    end else if (req_s != req_seen_q) begin
                        req_seen_q <= req_s;
                        xr_q       <= xreq_p_q;
                        first_q    <= 1'b1;
                        cur_addr_q <= {xreq_p_q.addr[31:3], 3'h0};
                        if (!xreq_p_q.burst) begin
                            lb_req_o       <= {xreq_p_q.addr, xreq_p_q.be,
                                               1'b0, `PTRLB_LEN_ONE};
                            lb_req_valid_o <= 1'b1;
                            s_state_q      <= S_ADDR;
                        end else if (xreq_p_q.addr[`PTRLB_WORD_BIT]) begin
                            lb_req_o       <= {xreq_p_q.addr, `PTRLB_BE_HI,
                                               1'b0, `PTRLB_LEN_ONE};
                            lb_req_valid_o <= 1'b1;
                            s_state_q      <= S_ADDR;
                        end else begin
                            s_state_q <= S_PAUSE;
                        end
                    end
                end
                S_PAUSE: begin
                    if (stop_s != stop_ack_q) begin
                        stop_ack_q <= stop_s;
                        s_state_q  <= S_IDLE;
                    end else if (({fill_ent, 1'b0} <= TH_REF) && (len_c != 8'h00)) begin
                        lb_req_o       <= {cur_addr_q, `PTRLB_BE_ALL, 1'b1, len_c};
                        lb_req_valid_o <= 1'b1;
                        s_state_q      <= S_ADDR;
                    end
                end
                S_ADDR: begin
                    if (lb_rsp_i.merr) begin
                        lb_req_valid_o <= 1'b0;
                        evt_code_q     <= PTRLB_EV_MERR;
                        evt_tgl_q      <= ~evt_tgl_q;
                        s_state_q      <= S_IDLE;
                    end else if (lb_rsp_i.rearb) begin
                        lb_req_valid_o <= 1'b0;
                        if (first_q) begin
                            evt_code_q <= PTRLB_EV_RETRY;
                            evt_tgl_q  <= ~evt_tgl_q;
                            s_state_q  <= S_IDLE;
                        end else begin
                            s_state_q <= S_PAUSE;
                        end
                    end else if (lb_rsp_i.addr_ack) begin
                        lb_req_valid_o <= 1'b0;
                        beats_q        <= '0;
                        s_state_q      <= S_DATA;
                    end
                end
                S_DATA: begin
                    if (lb_rsp_i.merr) begin
                        evt_code_q <= PTRLB_EV_MERR;
                        evt_tgl_q  <= ~evt_tgl_q;
                        s_state_q  <= S_IDLE;
                    end else if (lb_rsp_i.rd_valid) begin
                        beats_q <= beats_q + 8'h01;
                        first_q <= 1'b0;
                        if (!xr_q.burst) begin
                            word_q     <= xr_q.addr[`PTRLB_WORD_BIT] ?
                                          lb_rsp_i.rd_data[63:32] : lb_rsp_i.rd_data[31:0];
                            evt_code_q <= PTRLB_EV_DATA;
                            evt_tgl_q  <= ~evt_tgl_q;
                            s_state_q  <= S_IDLE;
                        end else begin
                            cur_addr_q <= cur_addr_q + `PTRLB_DW_BYTES;
                            if (cur_addr_q == LIM_ADDR) begin
                                evt_code_q <= PTRLB_EV_DATA;
                                evt_tgl_q  <= ~evt_tgl_q;
                                s_state_q  <= S_IDLE;
                            end else if (last_beat) begin
                                s_state_q <= S_PAUSE;
                            end
                        end
                    end
                end
            endcase
        end
    end
endmodule // ptrlb_bridge

// file: ptrlb_bridge_tb.sv
// self-checking bench of the pci target read path
`timescale 1ns/1ps
module ptrlb_bridge_tb import ptrlb_pkg::*;;
    logic           clk_sys = 1'b0, clk_pci = 1'b0, rst = 1'b1, rq_v = 1'b0, dph = 1'b0;
    logic           pend = 1'b0, slow = 1'b0, ready, rd_v, err, lb_v;
    logic [1:0]     mode = 2'h0;
    logic [3:0]     b;
    logic [31:0]    rd_d, a;
    ptrlb_pci_req_t rq = '0;
    ptrlb_term_t    term, t;
    ptrlb_lb_req_t  lb_q;
    ptrlb_lb_rsp_t  lb_r;
    int             fail_count = 0, compares = 0, seed = 73179, errs = 0, nw;
    initial forever #2.5 clk_sys = ~clk_sys;
    initial begin
        #7;
        forever #32 clk_pci = ~clk_pci;
    end
    always @(negedge clk_pci) if (err === 1'b1) errs++;
    ptrlb_bridge ptrlb_bridge_inst (.clk_sys_i(clk_sys), .rst_i(rst), .clk_pci_i(clk_pci),
        .pci_req_valid_i(rq_v), .pci_req_i(rq), .pci_dphase_i(dph), .pci_end_i(pend),
        .pci_req_ready_o(ready), .pci_rd_valid_o(rd_v), .pci_rd_data_o(rd_d), .pci_term_o(term),
        .pci_err_strobe_o(err), .lb_req_valid_o(lb_v), .lb_req_o(lb_q), .lb_rsp_i(lb_r));
    ptrlb_lb_slv ptrlb_lb_slv_inst (.clk_i(clk_sys), .mode_i(mode), .slow_i(slow),
        .req_valid_i(lb_v), .req_i(lb_q), .rsp_o(lb_r));
    // ----
    // tasks
    // ----
    task automatic check(input string nm, input logic [31:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic rd(input logic [3:0] c, input logic [31:0] ad, input int ph);
        int k;
        k = 0;
        nw = 0;
        t = PTRLB_TERM_NONE;
        while (ready !== 1'b1 && k < 99) begin
            k++;
            @(negedge clk_pci);
        end
        rq = '{c, ad, b};
        rq_v = 1'b1;
        @(negedge clk_pci);
        rq_v = 1'b0;
        while (t == PTRLB_TERM_NONE && nw < ph && k < 400) begin
            @(negedge clk_pci);
            k++;
            t = term;
            if (rd_v === 1'b1) begin
                check("word", rd_d, {16'h0, ad[15:2], 2'h0} + 32'(nw) * 32'h4);
                nw++;
                dph = 1'b1;
                @(negedge clk_pci);
                dph = 1'b0;
            end
        end
        check("answer", 32'(k < 400), 32'h1);
        if (t == PTRLB_TERM_NONE) pend = 1'b1;
        @(negedge clk_pci);
        pend = 1'b0;
    endtask
    // ----
    // scenarios
    // ----
    initial begin
        #400000;
        check("watchdog", 32'h0, 32'h1);
        print_verdict();
    end
    initial begin
        repeat (10) @(negedge clk_pci);
        rst = 1'b0;
        repeat (4) @(negedge clk_pci);
        for (int i = 0; i < 2; i++) begin
            rq = '{i ? 4'ha : 4'h2, 32'h100, 4'hf};
            rq_v = 1'b1;
            repeat (8) @(negedge clk_pci);
            rq_v = 1'b0;
            check("ignored", ptrlb_lb_slv_inst.n_req, 32'h0);
            check("ready", ready, 32'h1);
        end
        repeat (4) begin
            a = $random(seed) & 32'hfffc;
            b = 4'($random(seed));
            b = b ? b : 4'h8;
            rd(4'h6, a, 3);
            check("term", t, PTRLB_TERM_DISC_DATA);
            check("phases", nw, 32'h1);
            check("lb addr", ptrlb_lb_slv_inst.last_q.addr,
                  a | (b[0] ? 0 : b[1] ? 1 : b[2] ? 2 : 3));
            check("lb be", ptrlb_lb_slv_inst.last_q.be, a[2] ? {b, 4'h0} : {4'h0, b});
            check("lb burst", ptrlb_lb_slv_inst.last_q.burst, 32'h0);
        end
        for (int i = 0; i < 5; i++) begin
            slow = (i == 4);
            a = ($random(seed) & 32'h7ff8) | (i[0] ? 32'h4 : 32'h0);
            rd(i[1] ? 4'he : 4'hc, a, 3 + 2 * i);
        end
        check("slow stop", t, PTRLB_TERM_DISC_DATA);
        slow = 1'b0;
        rd(4'hc, 32'hffe8, 10);
        check("window words", nw, 32'h6);
        for (int i = 1; i < 3; i++) begin
            mode = 2'(i);
            rd(4'h6, 32'h40, 1);
            check("retry", t, PTRLB_TERM_RETRY);
        end
        mode = 2'h0;
        check("err strobe", errs, 32'h1);
        print_verdict();
    end
endmodule // ptrlb_bridge_tb

// file: ptrlb_chk.sv
// checker of the pci target read path
`timescale 1ns/1ps
module ptrlb_chk import ptrlb_pkg::*; #(
    parameter logic [31:0] LB_BASE = 32'h0,
    parameter logic [31:0] BAR_LEN = 32'h1_0000
) (
    // clocks
    input wire logic        clk_sys_i,
    input wire logic        rst_i,
    input wire logic        clk_pci_i,
    // pci side
    input wire logic        pci_dphase_i,
    input wire logic        pci_end_i,
    input wire logic        pci_req_ready_o,
    input wire logic        pci_rd_valid_o,
    input wire logic [31:0] pci_rd_data_o,
    input ptrlb_term_t      pci_term_o,
    // local side
    input wire logic        lb_req_valid_o,
    input ptrlb_lb_req_t    lb_req_o,
    input ptrlb_lb_rsp_t    lb_rsp_i
);
    // ----
    // properties
    // ----
    wire logic [31:0] lim = (LB_BASE & ~(BAR_LEN - 32'h1)) + BAR_LEN;
    wire logic        bv  = lb_req_valid_o && lb_req_o.burst;
    sequence wait_s;
        lb_req_valid_o && !lb_rsp_i.addr_ack && !lb_rsp_i.rearb && !lb_rsp_i.merr;
    endsequence
    sequence held_s;
        pci_rd_valid_o && pci_term_o == PTRLB_TERM_DISC_DATA && !pci_dphase_i && !pci_end_i;
    endsequence
    burst_be_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        bv |-> lb_req_o.be == 8'hff) else $error("burst lanes not all set");
    burst_align_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        bv |-> lb_req_o.addr[2:0] == 3'h0) else $error("burst not aligned");
    window_end_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        bv |-> lb_req_o.addr + {lb_req_o.len, 3'h0} <= lim) else $error("burst past window");
    single_len_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        lb_req_valid_o && !lb_req_o.burst |-> lb_req_o.len == 8'h01) else $error("long single");
    req_hold_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        wait_s |=> lb_req_valid_o && $stable(lb_req_o)) else $error("local request dropped");
    retry_a: assert property (@(posedge clk_pci_i) disable iff (rst_i)
        pci_term_o == PTRLB_TERM_RETRY |-> !pci_rd_valid_o ##1 pci_term_o != PTRLB_TERM_RETRY)
        else $error("retry carries data or lasts");
    word_hold_a: assert property (@(posedge clk_pci_i) disable iff (rst_i)
        held_s |=> pci_rd_valid_o && $stable(pci_rd_data_o)) else $error("word not held");
    busy_a: assert property (@(posedge clk_pci_i) disable iff (rst_i)
        pci_rd_valid_o |-> !pci_req_ready_o) else $error("ready while serving");
endmodule // ptrlb_chk

bind ptrlb_bridge ptrlb_chk #(.LB_BASE(LB_BASE), .BAR_LEN(BAR_LEN)) ptrlb_chk_inst (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .clk_pci_i(clk_pci_i), .pci_dphase_i(pci_dphase_i),
    .pci_end_i(pci_end_i), .pci_req_ready_o(pci_req_ready_o), .pci_rd_valid_o(pci_rd_valid_o),
    .pci_rd_data_o(pci_rd_data_o), .pci_term_o(pci_term_o), .lb_req_valid_o(lb_req_valid_o),
    .lb_req_o(lb_req_o), .lb_rsp_i(lb_rsp_i));

// file: ptrlb_defines.svh
// shared constants of the pci target read path
`ifndef PTRLB_DEFINES_SVH
`define PTRLB_DEFINES_SVH
`define PTRLB_CMD_IORD     4'h2
`define PTRLB_CMD_MEMRD    4'h6
`define PTRLB_CMD_CFGRD    4'ha
`define PTRLB_CMD_MEMRDMUL 4'hc
`define PTRLB_CMD_MEMRDLN  4'he
`define PTRLB_BE_ALL       8'hff
`define PTRLB_BE_HI        8'hf0
`define PTRLB_BE_LO_NONE   4'h0
`define PTRLB_WORD_BIT     2
`define PTRLB_DW_LSB       3
`define PTRLB_DW_BYTES     32'h8
`define PTRLB_LSB_ONE      32'h1
`define PTRLB_LEN_ONE      8'h01
`define PTRLB_FLUSH_WAIT   2'h3
`endif

// file: ptrlb_lb_slv.sv
// local bus slave model
`timescale 1ns/1ps
module ptrlb_lb_slv import ptrlb_pkg::*; (
    // clock and behaviour: mode 0 data, 1 rearbitrate, 2 master error
    input wire logic       clk_i,
    input wire logic [1:0] mode_i,
    input wire logic       slow_i,
    // local bus
    input wire logic       req_valid_i,
    input ptrlb_lb_req_t   req_i,
    output ptrlb_lb_rsp_t  rsp_o
);
    ptrlb_lb_req_t last_q;
    int            n_req = 0;
    logic [31:0]   a;
    initial begin
        rsp_o = '0;
        forever begin
            @(posedge clk_i);
            #1;
            if (req_valid_i) begin
                last_q = req_i;
                n_req++;
                a = {req_i.addr[31:3], 3'h0};
                rsp_o.addr_ack = (mode_i == 2'h0);
                rsp_o.rearb = (mode_i == 2'h1);
                rsp_o.merr = (mode_i == 2'h2);
                @(posedge clk_i);
                #1;
                {rsp_o.addr_ack, rsp_o.rearb, rsp_o.merr} = 3'h0;
                for (int i = 0; mode_i == 2'h0 && i < (last_q.burst ? int'(last_q.len) : 1); i++) begin
                    if (slow_i) begin
                        repeat (60) @(posedge clk_i);
                        #1;
                    end
                    rsp_o.rd_valid = 1'b1;
                    rsp_o.rd_data = {a + 32'h4, a};
                    a += 32'h8;
                    @(posedge clk_i);
                    #1;
                    rsp_o.rd_valid = 1'b0;
                    rsp_o.rd_data = ~rsp_o.rd_data;
                end
            end
        end
    end
endmodule // ptrlb_lb_slv

// file: ptrlb_pkg.sv
// types of the pci target read path
package ptrlb_pkg;
    typedef enum logic [1:0] {
        PTRLB_TERM_NONE      = 2'h0,
        PTRLB_TERM_RETRY     = 2'h1,
        PTRLB_TERM_DISC_DATA = 2'h2
    } ptrlb_term_t;
    typedef enum logic [1:0] {
        PTRLB_EV_DATA  = 2'h0,
        PTRLB_EV_RETRY = 2'h1,
        PTRLB_EV_MERR  = 2'h2
    } ptrlb_evt_t;
    typedef struct packed {
        logic [3:0]  cmd;
        logic [31:0] addr;
        logic [3:0]  be;
    } ptrlb_pci_req_t;
    typedef struct packed {
        logic [31:0] addr;
        logic [7:0]  be;
        logic        burst;
        logic [7:0]  len;
    } ptrlb_lb_req_t;
    typedef struct packed {
        logic        addr_ack;
        logic        rearb;
        logic        merr;
        logic        rd_valid;
        logic        bterm;
        logic [63:0] rd_data;
    } ptrlb_lb_rsp_t;
    typedef struct packed {
        logic        burst;
        logic [31:0] addr;
        logic [7:0]  be;
    } ptrlb_xreq_t;
endpackage

// file: ptrlb_sync.sv
// two flip-flop synchroniser
`timescale 1ns/1ps
module ptrlb_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // data
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= '0;
            q_o    <= '0;
        end else begin
            meta_q <= d_i;
            q_o    <= meta_q;
        end
    end
endmodule // ptrlb_sync
